// *** common/clocked_serial_pkg.sv ***
// constants of the clocked serial interface and its baud generator
package clocked_serial_pkg;
    localparam int addr_width = 12;
    localparam logic [11:0] ctl0_offset = 12'h000;
    localparam logic [11:0] ctl1_offset = 12'h004;
    localparam logic [11:0] ctl2_offset = 12'h008;
    localparam logic [11:0] status_offset = 12'h00c;
    localparam logic [11:0] tx_offset = 12'h010;
    localparam logic [11:0] rx_offset = 12'h014;
    localparam logic [11:0] prescaler_mode_offset = 12'h018;
    // printed register index; the byte address is four times it, low bits decoded
    localparam logic [31:0] prescaler_compare_index = 32'hfffff8b1;
    localparam logic [11:0] prescaler_compare_offset = {prescaler_compare_index[9:0], 2'b00};
    // control register zero fields
    localparam int pwr_bit = 7;
    localparam int txe_bit = 6;
    localparam int rxe_bit = 5;
    localparam int dir_bit = 4;
    localparam int tms_bit = 1;
    localparam int sce_bit = 0;
    // control register one fields
    localparam int ckp_bit = 4;
    localparam int dap_bit = 3;
    localparam int cks_lsb = 0;
    // status fields
    localparam int tsf_bit = 7;
    localparam int ove_bit = 0;
    // prescaler mode fields
    localparam int bgce_bit = 4;
    localparam int prsm_k_lsb = 0;
    localparam logic [2:0] cks_external = 3'h7;
    localparam logic [2:0] cks_baud = 3'h6;
    localparam logic [7:0] reg8_reset = 8'h00;
    localparam logic [15:0] reg16_reset = 16'h0000;
    localparam logic [4:0] len_base = 5'h08;
    localparam logic [4:0] len_max = 5'h10;
    localparam logic [1:0] resp_okay = 2'b00;
    localparam logic [1:0] resp_slverr = 2'b10;
    typedef enum logic [1:0] {st_idle, st_run, st_tail} engine_state_type;
endpackage

// *** hdl/baud_rate_generator.sv ***
// baud rate generator: main clock over 2^(k+1) times n
`timescale 1ns/1ps
`default_nettype none
module baud_rate_generator
    import clocked_serial_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic enable,
    input wire logic [1:0] mode,
    input wire logic [7:0] compare,
    output logic tick
);
    logic [3:0] pre_q;
    logic [7:0] cmp_q;
    logic tick_q;
    wire logic [3:0] pre_mask = 4'((5'h2 << mode) - 5'h1);
    wire logic pre_end = (pre_q & pre_mask) == pre_mask;
    // 8'h00 wraps to 255, so the compare period is 256
    wire logic [7:0] cmp_last = compare - 8'h01;
    wire logic cmp_end = pre_end && cmp_q == cmp_last;

    always_ff @(posedge aclk) begin
        if (!aresetn || !enable) begin
            pre_q <= 4'h0;
            cmp_q <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            pre_q <= pre_end ? 4'h0 : pre_q + 4'h1;
            cmp_q <= cmp_end ? 8'h00 : (pre_end ? cmp_q + 8'h01 : cmp_q);
            tick_q <= cmp_end;
        end
    end

    assign tick = tick_q;
endmodule
`default_nettype wire

// *** hdl/clocked_serial_interface.sv ***
// clocked serial interface with axi4-lite register access
// Operation
// - continuous transmit raises transmit-enable irq when buffer moves into shifter
// - single modes never raise transmit-enable irq; receive-complete irq at completion
// - with reception enabled, receive-complete irq on new word and on overrun
// - with data phase 1, busy clears half a serial clock after receive-complete irq
// - powered down, clock pin floats for select all ones, else idles at inverted polarity
// - idle clock pin level follows polarity and clock select rewrites at once
// - powered down, data-out is low, or first transmit bit with transmit enable and data phase 1
// - idle data-out follows transmit enable, bit order and data phase rewrites
// - single mode ignores transmit writes while busy and starts nothing
// - single receive-only mode does not start on a receive read while busy
// - overrun flag is set in single and continuous modes alike
// - master continuous receive runs the clock until scan enable is cleared
// - in receive-only mode, receive register read triggers the next reception
// - baud clock is main clock over 2^(k+1) times n, n zero meaning 256
// - baud generator output feeds the serial unit and the baud_clock_tick port
// - overrun flag clears on writing zero; writing one has no effect
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module clocked_serial_interface
    import clocked_serial_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe_n,
    output logic serial_data_out_pin,
    input wire logic serial_data_in_pin,
    output logic transmit_enable_irq,
    output logic receive_complete_irq,
    output logic baud_clock_tick
);
    function automatic logic is_at(input logic [11:0] addr, input logic [11:0] off);
        is_at = addr[11:2] == off[11:2];
    endfunction

    function automatic logic [4:0] word_len(input logic [3:0] cl);
        word_len = cl[3] ? len_max : len_base + {2'b00, cl[2:0]};
    endfunction

    function automatic logic out_bit(input logic [15:0] v, input logic dir,
                                     input logic [4:0] len);
        out_bit = dir ? v[0] : v[4'(len - 5'h01)];
    endfunction

    function automatic logic [15:0] rx_align(input logic [15:0] v, input logic dir,
                                             input logic [4:0] len);
        rx_align = dir ? v >> (len_max - len) : v & 16'((17'h1 << len) - 17'h1);
    endfunction

    function automatic logic [6:0] half_mask(input logic [2:0] cks);
        half_mask = 7'((8'h2 << cks) - 8'h1);
    endfunction

    // bus handshake state
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [11:0] waddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    // software registers
    logic [7:0] ctl0_q, ctl1_q, ctl2_q, prsm_q, prscm_q;
    logic [15:0] tx_buf_q, rx_q;
    logic ove_q, rx_full_q, tx_pend_q;
    // engine
    engine_state_type state_q;
    logic [15:0] tx_sh_q, rx_sh_q;
    logic [4:0] cnt_q;
    logic [6:0] div_q;
    logic sck_q, sck_oe_n_q, sdo_q, sck_prev_q, irq_t_q, irq_r_q;
    logic baud_tick;

    wire logic pwr = ctl0_q[pwr_bit];
    wire logic txe = ctl0_q[txe_bit];
    wire logic rxe = ctl0_q[rxe_bit];
    wire logic dir = ctl0_q[dir_bit];
    wire logic tms = ctl0_q[tms_bit];
    wire logic sce = ctl0_q[sce_bit];
    wire logic ckp = ctl1_q[ckp_bit];
    wire logic dap = ctl1_q[dap_bit];
    wire logic [2:0] cks = ctl1_q[cks_lsb +: 3];
    wire logic [4:0] len = word_len(ctl2_q[3:0]);

    // register bus decode
    wire logic wr_go = !awready_q && !wready_q && !bvalid_q;
    wire logic rd_go = s_axi_arvalid && arready_q;
    wire logic w_ctl0 = wr_go && wstrb_q[0] && is_at(waddr_q, ctl0_offset);
    wire logic w_ctl1 = wr_go && wstrb_q[0] && is_at(waddr_q, ctl1_offset);
    wire logic w_ctl2 = wr_go && wstrb_q[0] && is_at(waddr_q, ctl2_offset);
    wire logic w_stat = wr_go && wstrb_q[0] && is_at(waddr_q, status_offset);
    wire logic w_tx = wr_go && (&wstrb_q[1:0]) && is_at(waddr_q, tx_offset);
    wire logic w_prsm = wr_go && wstrb_q[0] && is_at(waddr_q, prescaler_mode_offset);
    wire logic w_prscm = wr_go && wstrb_q[0] && is_at(waddr_q, prescaler_compare_offset);
    wire logic w_map = is_at(waddr_q, ctl0_offset) || is_at(waddr_q, ctl1_offset)
        || is_at(waddr_q, ctl2_offset) || is_at(waddr_q, status_offset)
        || is_at(waddr_q, tx_offset) || is_at(waddr_q, rx_offset)
        || is_at(waddr_q, prescaler_mode_offset) || is_at(waddr_q, prescaler_compare_offset);
    wire logic r_rx = rd_go && is_at(s_axi_araddr, rx_offset);
    wire logic busy = state_q != st_idle;
    wire logic [7:0] status_val = {busy, 6'h00, ove_q};
    wire logic r_map = is_at(s_axi_araddr, ctl0_offset) || is_at(s_axi_araddr, ctl1_offset)
        || is_at(s_axi_araddr, ctl2_offset) || is_at(s_axi_araddr, status_offset)
        || is_at(s_axi_araddr, tx_offset) || is_at(s_axi_araddr, rx_offset)
        || is_at(s_axi_araddr, prescaler_mode_offset)
        || is_at(s_axi_araddr, prescaler_compare_offset);
    wire logic [31:0] rd_val =
        is_at(s_axi_araddr, ctl0_offset) ? {24'h0, ctl0_q} :
        is_at(s_axi_araddr, ctl1_offset) ? {24'h0, ctl1_q} :
        is_at(s_axi_araddr, ctl2_offset) ? {24'h0, ctl2_q} :
        is_at(s_axi_araddr, status_offset) ? {24'h0, status_val} :
        is_at(s_axi_araddr, tx_offset) ? {16'h0, tx_buf_q} :
        is_at(s_axi_araddr, rx_offset) ? {16'h0, rx_q} :
        is_at(s_axi_araddr, prescaler_mode_offset) ? {24'h0, prsm_q} :
        is_at(s_axi_araddr, prescaler_compare_offset) ? {24'h0, prscm_q} : 32'h0;

    // serial clock edges, internal or from the pin
    wire logic idle_lvl = ~ckp;
    wire logic external = cks == cks_external;
    wire logic div_tick = (div_q & half_mask(cks)) == half_mask(cks);
    wire logic master_tick = (cks == cks_baud) ? baud_tick : div_tick;
    wire logic pin_edge = serial_clock_pin_i != sck_prev_q;
    wire logic lead = (state_q == st_run) && (external ? (pin_edge && sck_prev_q == idle_lvl)
        : (master_tick && sck_q == idle_lvl));
    wire logic trail = busy && (external ? (pin_edge && sck_prev_q != idle_lvl)
        : (master_tick && sck_q != idle_lvl));
    wire logic sample = (state_q == st_run) && (dap ? lead : trail);
    wire logic advance = (state_q == st_run) && (dap ? trail : lead);
    wire logic last = sample && cnt_q == len - 5'h01;
    wire logic finish = dap ? (state_q == st_tail && trail) : last;
    // continuous receive keeps going while scan enable stays set
    wire logic more = tms && (txe ? tx_pend_q : (rxe && sce));
    wire logic start_tx = w_tx && txe;
    wire logic start_rx = r_rx && !txe && rxe && sce;
    // starts only from idle, so busy writes and reads start nothing
    wire logic start = pwr && !busy && (start_tx || start_rx);
    wire logic load = start || (pwr && finish && more);
    wire logic [15:0] load_val = start ? wdata_q[15:0] : tx_buf_q;
    wire logic [15:0] rx_next = dir ? {serial_data_in_pin, rx_sh_q[15:1]}
        : {rx_sh_q[14:0], serial_data_in_pin};
    wire logic tx_take = w_tx && !(busy && !tms);
    wire logic sdo_idle = txe && dap && out_bit(tx_buf_q, dir, len);
    wire logic sdo_run = !txe ? 1'b0 : ((dap || lead) ? out_bit(tx_sh_q, dir, len) : sdo_q);

    baud_rate_generator u_baud (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(prsm_q[bgce_bit]),
        .mode(prsm_q[prsm_k_lsb +: 2]),
        .compare(prscm_q),
        .tick(baud_tick)
    );

    // axi4-lite write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= resp_okay;
            waddr_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && awready_q) begin
                awready_q <= 1'b0;
                waddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_q) begin
                wready_q <= 1'b0;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= w_map ? resp_okay : resp_slverr;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // axi4-lite read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= resp_okay;
        end else if (rd_go) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_val;
            rresp_q <= r_map ? resp_okay : resp_slverr;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // software registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl0_q <= reg8_reset;
            ctl1_q <= reg8_reset;
            ctl2_q <= reg8_reset;
            prsm_q <= reg8_reset;
            prscm_q <= reg8_reset;
            tx_buf_q <= reg16_reset;
        end else begin
            if (w_ctl0) ctl0_q <= wdata_q[7:0];
            if (w_ctl1) ctl1_q <= wdata_q[7:0];
            if (w_ctl2) ctl2_q <= wdata_q[7:0];
            if (w_prsm) prsm_q <= wdata_q[7:0];
            if (w_prscm) prscm_q <= wdata_q[7:0];
            if (tx_take) tx_buf_q <= wdata_q[15:0];
        end
    end

    // receive data, overrun and pending transmit word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_q <= reg16_reset;
            rx_full_q <= 1'b0;
            ove_q <= 1'b0;
            tx_pend_q <= 1'b0;
        end else begin
            if (last && rxe) rx_q <= rx_align(rx_next, dir, len);
            // a completing word wins over a same-cycle read
            rx_full_q <= (last && rxe) || (rx_full_q && !r_rx && pwr);
            // set wins over the clear; writing one leaves it alone
            ove_q <= (last && rxe && rx_full_q)
                || (ove_q && !(w_stat && !wdata_q[ove_bit]));
            if (!pwr) tx_pend_q <= 1'b0;
            else if (w_tx && busy && tms && txe) tx_pend_q <= 1'b1;
            else if (load) tx_pend_q <= 1'b0;
        end
    end

    // transfer engine
    always_ff @(posedge aclk) begin
        if (!aresetn || !pwr) begin
            state_q <= st_idle;
            cnt_q <= 5'h00;
            tx_sh_q <= reg16_reset;
            rx_sh_q <= reg16_reset;
        end else begin
            if (load) state_q <= st_run;
            else if (last && dap) state_q <= st_tail;
            else if (finish) state_q <= st_idle;
            if (load) cnt_q <= 5'h00;
            else if (sample) cnt_q <= cnt_q + 5'h01;
            if (load) tx_sh_q <= load_val;
            else if (advance) tx_sh_q <= dir ? tx_sh_q >> 1 : tx_sh_q << 1;
            if (sample) rx_sh_q <= rx_next;
        end
    end

    // pins, clock divider and interrupt pulses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= 7'h00;
            sck_q <= 1'b1;
            sck_oe_n_q <= 1'b1;
            sdo_q <= 1'b0;
            sck_prev_q <= 1'b1;
            irq_t_q <= 1'b0;
            irq_r_q <= 1'b0;
        end else begin
            div_q <= busy ? div_q + 7'h01 : 7'h00;
            sck_prev_q <= serial_clock_pin_i;
            if (busy && !external) sck_q <= master_tick ? ~sck_q : sck_q;
            else sck_q <= idle_lvl;
            sck_oe_n_q <= external;
            sdo_q <= busy ? sdo_run : sdo_idle;
            irq_t_q <= load && tms && txe;
            irq_r_q <= last && (rxe || !tms);
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign serial_clock_pin_o = sck_q;
    assign serial_clock_pin_oe_n = sck_oe_n_q;
    assign serial_data_out_pin = sdo_q;
    assign transmit_enable_irq = irq_t_q;
    assign receive_complete_irq = irq_r_q;
    assign baud_clock_tick = baud_tick;
endmodule
`default_nettype wire

// *** verif/clocked_serial_interface_tb_top.sv ***
// testbench for the clocked serial interface
`timescale 1ns/1ps
`default_nettype none
module clocked_serial_interface_tb_top;
    import clocked_serial_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0;
    logic r_r = 1'b0;
    logic [11:0] aw_addr = 12'h000, ar_addr = 12'h000;
    logic [31:0] w_data = 32'h0, r_data, rd;
    logic aw_r, w_r, b_v, ar_r, r_v, sck_o, sck_oe_n, sdo, sdi, tx_irq, rx_irq, tick;
    logic [1:0] b_resp, r_resp, rsp;
    logic [7:0] peer_rx;
    logic [7:0] cmps [3] = '{8'h03, 8'h03, 8'h00};
    logic [7:0] ks [3] = '{8'h00, 8'h01, 8'h00};
    logic [7:0] p0 [6] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h40, 8'h50};
    logic [7:0] p1 [6] = '{8'h00, 8'h10, 8'h07, 8'h00, 8'h08, 8'h08};
    logic [2:0] pe [6] = '{3'b100, 3'b000, 3'b010, 3'b100, 3'b101, 3'b100};
    int failures = 0, comparisons = 0, cycles = 0, tx_irqs = 0, rx_irqs = 0, g;
    wire sck = sck_oe_n ? 1'b1 : sck_o;
    always #2 aclk = ~aclk;
    clocked_serial_interface u_clocked_serial_interface (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
        .s_axi_wdata(w_data), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
        .s_axi_bresp(b_resp), .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_addr),
        .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_rdata(r_data), .s_axi_rresp(r_resp),
        .s_axi_rvalid(r_v), .s_axi_rready(r_r), .serial_clock_pin_i(sck),
        .serial_clock_pin_o(sck_o), .serial_clock_pin_oe_n(sck_oe_n),
        .serial_data_out_pin(sdo), .serial_data_in_pin(sdi), .transmit_enable_irq(tx_irq),
        .receive_complete_irq(rx_irq), .baud_clock_tick(tick));
    serial_peer u_serial_peer (.aclk(aclk), .sck(sck), .sdo(sdo), .send_word(8'h3c),
        .sdi(sdi), .got_word(peer_rx));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(negedge aclk) begin
        cycles++;
        tx_irqs += int'(tx_irq === 1'b1);
        rx_irqs += int'(rx_irq === 1'b1);
        if (cycles == 40000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        aw_addr <= a;
        w_data <= d;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= 1'b1;
        do begin
            @(negedge aclk);
            ta = aw_v && aw_r === 1'b1;
            tw = w_v && w_r === 1'b1;
            tb = b_v === 1'b1;
            @(posedge aclk);
            if (ta) aw_v <= 1'b0;
            if (tw) w_v <= 1'b0;
        end while (!tb);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er,
            input string name);
        logic ta, tr;
        ar_addr <= a;
        ar_v <= 1'b1;
        r_r <= 1'b1;
        do begin
            @(negedge aclk);
            ta = ar_v && ar_r === 1'b1;
            tr = r_v === 1'b1;
            rd = r_data;
            rsp = r_resp;
            @(posedge aclk);
            if (ta) ar_v <= 1'b0;
        end while (!tr);
        check(name, rd, exp);
        check(name, {30'h0, rsp}, {30'h0, er});
    endtask
    task automatic wait_rx;
        int n;
        n = 0;
        do begin
            @(negedge aclk);
            n++;
        end while (rx_irq !== 1'b1 && n < 400);
        check("rx irq", 32'(n < 400), 32'h1);
        @(posedge aclk);
    endtask
    task automatic tick_gap(output int gap);
        repeat (2) begin
            gap = 0;
            do begin
                @(negedge aclk);
                gap++;
            end while (tick !== 1'b1 && gap < 2000);
        end
        @(posedge aclk);
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd_chk(prescaler_mode_offset, 32'h0, resp_okay, "mode reset");
        rd_chk(prescaler_compare_offset, 32'h0, resp_okay, "compare reset");
        rd_chk(12'hffc, 32'h0, resp_slverr, "unmapped");
        for (int i = 0; i < 3; i++) begin
            wr(prescaler_mode_offset, 32'h0);
            wr(prescaler_compare_offset, {24'h0, cmps[i]});
            wr(prescaler_mode_offset, {24'h0, 8'h10 | ks[i]});
            rd_chk(prescaler_compare_offset, {24'h0, cmps[i]}, resp_okay, "compare rw");
            tick_gap(g);
            check("gap", g, (32'h2 << ks[i]) * (cmps[i] == 8'h0 ? 32'h100 : 32'(cmps[i])));
        end
        wr(prescaler_mode_offset, 32'h0);
        g = 0;
        repeat (600) begin
            @(negedge aclk);
            g += int'(tick === 1'b1);
        end
        @(posedge aclk);
        check("ticks off", g, 32'h0);
        wr(tx_offset, 32'h80);
        for (int i = 0; i < 6; i++) begin
            wr(ctl0_offset, {24'h0, p0[i]});
            wr(ctl1_offset, {24'h0, p1[i]});
            @(negedge aclk);
            check("clock release", sck_oe_n, pe[i][1]);
            if (!pe[i][1]) check("clock idle", sck_o, pe[i][2]);
            check("data idle", sdo, pe[i][0]);
            @(posedge aclk);
        end
        wr(ctl0_offset, 32'h0);
        wr(ctl1_offset, 32'h01);
        wr(ctl2_offset, 32'h0);
        wr(ctl0_offset, 32'h61);
        wr(ctl0_offset, 32'he1);
        wr(tx_offset, 32'ha5);
        wr(tx_offset, 32'h5a);
        wait_rx;
        rd_chk(rx_offset, 32'h3c, resp_okay, "rx word");
        repeat (80) @(posedge aclk);
        rd_chk(status_offset, 32'h0, resp_okay, "idle after single");
        check("peer word", peer_rx, 8'ha5);
        check("tx irq single", tx_irqs, 32'h0);
        wr(tx_offset, 32'h11);
        wait_rx;
        wr(tx_offset, 32'h22);
        wait_rx;
        rd_chk(status_offset, 32'h1, resp_okay, "overrun set");
        check("rx irqs", rx_irqs, 32'h3);
        wr(status_offset, 32'h1);
        rd_chk(status_offset, 32'h1, resp_okay, "overrun kept");
        wr(status_offset, 32'h0);
        rd_chk(status_offset, 32'h0, resp_okay, "overrun clear");
        wr(ctl0_offset, 32'h0);
        wr(ctl0_offset, 32'h62);
        wr(ctl0_offset, 32'he2);
        wr(tx_offset, 32'h42);
        wait_rx;
        check("tx irq continuous", tx_irqs, 32'h1);
        rd_chk(rx_offset, 32'h3c, resp_okay, "rx continuous");
        check("peer word", peer_rx, 8'h42);
        wr(ctl0_offset, 32'h0);
        wr(ctl0_offset, 32'ha3);
        rd_chk(rx_offset, 32'h3c, resp_okay, "dummy");
        wait_rx;
        wr(ctl0_offset, 32'ha2);
        wait_rx;
        rd_chk(status_offset, 32'h1, resp_okay, "stop");
        rd_chk(rx_offset, 32'h3c, resp_okay, "last");
        wrap_up();
    end
endmodule
`default_nettype wire

// *** verif/clocked_serial_props.sv ***
// port checker for the clocked serial interface
`timescale 1ns/1ps
`default_nettype none
module clocked_serial_props
    import clocked_serial_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic serial_clock_pin_o,
    input wire logic serial_clock_pin_oe_n,
    input wire logic serial_data_out_pin,
    input wire logic transmit_enable_irq,
    input wire logic baud_clock_tick
);
    logic [7:0] c0_q, c1_q, pm_q, cm_q;
    logic [15:0] tx_q;
    logic [12:0] gap_q, want_gap;
    logic [1:0] age_q;
    logic seen_q;
    wire wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire baud_wr = wr && (s_axi_awaddr == prescaler_mode_offset
        || s_axi_awaddr == prescaler_compare_offset);
    assign want_gap = 13'(cm_q == 8'h00 ? 9'h100 : {1'b0, cm_q}) << (3'(pm_q[1:0]) + 3'h1);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            c0_q <= 8'h00;
            c1_q <= 8'h00;
            pm_q <= 8'h00;
            cm_q <= 8'h00;
            tx_q <= 16'h0000;
            age_q <= 2'h0;
            seen_q <= 1'b0;
            gap_q <= 13'h0000;
        end else begin
            if (age_q != 2'h3) age_q <= age_q + 2'h1;
            if (wr && s_axi_awaddr == ctl0_offset) c0_q <= s_axi_wdata[7:0];
            if (wr && s_axi_awaddr == ctl1_offset) c1_q <= s_axi_wdata[7:0];
            if (wr && s_axi_awaddr == prescaler_mode_offset) pm_q <= s_axi_wdata[7:0];
            if (wr && s_axi_awaddr == prescaler_compare_offset) cm_q <= s_axi_wdata[7:0];
            if (wr && s_axi_awaddr == tx_offset && !c0_q[pwr_bit]) tx_q <= s_axi_wdata[15:0];
            seen_q <= pm_q[bgce_bit] && !baud_wr && (seen_q || baud_clock_tick);
            gap_q <= baud_clock_tick ? 13'h0001 : gap_q + 13'h0001;
        end
    end
    chk_baud_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        !pm_q[bgce_bit] && !$past(pm_q[bgce_bit], 2) |-> !baud_clock_tick)
        else $error("baud tick while generator disabled");
    chk_baud_period: assert property (@(posedge aclk) disable iff (!aresetn)
        baud_clock_tick && seen_q |-> gap_q == want_gap)
        else $error("baud tick spacing wrong");
    chk_idle_clock: assert property (@(posedge aclk) disable iff (!aresetn)
        age_q == 2'h3 && !$past(c0_q[pwr_bit], 2) && $past(c1_q[2:0], 2) != cks_external
        |-> serial_clock_pin_o == !$past(c1_q[ckp_bit], 2) && !serial_clock_pin_oe_n)
        else $error("idle clock pin level wrong");
    chk_clock_float: assert property (@(posedge aclk) disable iff (!aresetn)
        age_q == 2'h3 && $past(c1_q[2:0], 2) == cks_external |-> serial_clock_pin_oe_n)
        else $error("clock pin driven with external clock");
    chk_idle_data_low: assert property (@(posedge aclk) disable iff (!aresetn)
        age_q == 2'h3 && !$past(c0_q[pwr_bit], 2)
        && !($past(c0_q[txe_bit], 2) && $past(c1_q[dap_bit], 2)) |-> !serial_data_out_pin)
        else $error("idle data out not low");
    chk_idle_data_lsb: assert property (@(posedge aclk) disable iff (!aresetn)
        age_q == 2'h3 && !$past(c0_q[pwr_bit], 2) && $past(c0_q[txe_bit], 2)
        && $past(c1_q[dap_bit], 2) && $past(c0_q[dir_bit], 2)
        |-> serial_data_out_pin == $past(tx_q[0], 2))
        else $error("idle data out not first bit");
    chk_single_no_txirq: assert property (@(posedge aclk) disable iff (!aresetn)
        !c0_q[tms_bit] && !$past(c0_q[tms_bit]) |-> !transmit_enable_irq)
        else $error("transmit irq in single mode");
    chk_txirq_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
        transmit_enable_irq |=> !transmit_enable_irq)
        else $error("transmit irq longer than one cycle");
endmodule
bind clocked_serial_interface clocked_serial_props u_clocked_serial_props (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_wready, .serial_clock_pin_o, .serial_clock_pin_oe_n, .serial_data_out_pin,
    .transmit_enable_irq, .baud_clock_tick);
`default_nettype wire

// *** verif/serial_peer.sv ***
// serial peer that shifts a word against the device clock
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
    input wire logic aclk,
    input wire logic sck,
    input wire logic sdo,
    input wire logic [7:0] send_word,
    output logic sdi,
    output logic [7:0] got_word
);
    logic sck_q = 1'b1;
    logic [2:0] cnt = 3'h0;
    logic [4:0] idle = 5'h00;
    initial sdi = 1'b0;
    initial got_word = 8'h00;
    // leading edge shows a bit, trailing edge takes one
    always @(posedge aclk) begin
        sck_q <= sck;
        idle <= sck ? (idle == 5'h1f ? idle : idle + 5'h01) : 5'h00;
        if (idle == 5'h1f) cnt <= 3'h0;
        if (idle > 5'h04) sdi <= ~sdi;
        if (sck_q && !sck) sdi <= send_word[3'h7 - cnt];
        if (!sck_q && sck) begin
            got_word <= {got_word[6:0], sdo};
            cnt <= cnt + 3'h1;
        end
    end
endmodule
`default_nettype wire
